// file: bench/ssc_partner.sv
// Far-side peer: an SPI master and an I2C master clocking bytes in, bus lines pulled up
`timescale 1ns/1ns
module ssc_partner (
  input  wire logic clk_in,
  output logic      sck_out,
  output logic      sdi_out,
  output logic      ss_n_out,
  output logic      sda_out,
  output logic      scl_out
);
  initial begin
    sck_out = 1'b0;
    sdi_out = 1'b0;
    ss_n_out = 1'b1;
    sda_out = 1'b1;
    scl_out = 1'b1;
  end
  // MSB first, data set while clock low and held across the rising sample edge
  task automatic send(input logic [7:0] b);
    ss_n_out <= 1'b0;
    repeat (4) @(posedge clk_in);
    for (int i = 7; i >= 0; i--) begin
      sdi_out <= b[i];
      repeat (4) @(posedge clk_in);
      sck_out <= 1'b1;
      repeat (4) @(posedge clk_in);
      sck_out <= 1'b0;
    end
    repeat (4) @(posedge clk_in);
    ss_n_out <= 1'b1;
    sdi_out <= ~b[0]; // Released line must not show a stale bit
    @(posedge clk_in);
  endtask
  // Bus frame: start, 18 bit slots (two bytes, each with a released ninth slot), stop
  // Data moves only while the clock is low, so no false start or stop appears
  task automatic frame(input logic [17:0] bits);
    sda_out <= 1'b0; // Start while clock high
    repeat (4) @(posedge clk_in);
    for (int i = 17; i >= 0; i--) begin
      scl_out <= 1'b0;
      repeat (2) @(posedge clk_in);
      sda_out <= bits[i];
      repeat (2) @(posedge clk_in);
      scl_out <= 1'b1;
      repeat (4) @(posedge clk_in);
    end
    scl_out <= 1'b0;
    repeat (2) @(posedge clk_in);
    sda_out <= 1'b0;
    repeat (2) @(posedge clk_in);
    scl_out <= 1'b1;
    repeat (4) @(posedge clk_in);
    sda_out <= 1'b1; // Stop
    repeat (4) @(posedge clk_in);
  endtask
endmodule // ssc_partner

// file: bench/ssc_top_bench.sv
// Self-checking bench for the serial port control block
`timescale 1ns/1ns
module ssc_top_bench;
  import ssc_pkg::*;
  logic        clk_sys_in = 0, reset_in = 1, ce_in = 1, psel_in = 0, penable_in = 0;
  logic        pwrite_in = 0, timer_in, sck_in, sdi_in, ss_n_in, sda_in, scl_in, err;
  logic        pready_out, pslverr_out, irq_out, sck_out, sck_oe_out, sdo_out, sdo_oe_out;
  logic        sda_out, sda_oe_out, scl_out, scl_oe_out, sck_p, sda_p, scl_p;
  logic        spi_pins_own_out, ss_pin_own_out, i2c_pins_own_out;
  logic [2:0]  tcnt = 3'h0;
  logic [11:0] paddr_in = 12'h000;
  logic [31:0] pwdata_in = 32'h0, prdata_out, rd;
  logic [31:0] halves [4] = '{32'h2, 32'h8, 32'h20, 32'h8};
  int          num_errors = 0, tests_run = 0, n;
  always #10 clk_sys_in = ~clk_sys_in;
  // Timer stand-in: one rising edge every eight clocks
  always @(posedge clk_sys_in) tcnt <= tcnt + 3'h1;
  assign timer_in = tcnt[2];
  // Shared lines: an enabled driver wins, else the peer's level shows
  assign sck_in = sck_oe_out ? sck_out : sck_p;
  assign sda_in = sda_oe_out ? sda_out : sda_p;
  assign scl_in = scl_oe_out ? scl_out : scl_p;
  ssc_top dut_u (.*);
  ssc_partner p_u (.clk_in(clk_sys_in), .sck_out(sck_p), .sdi_out(sdi_in),
                   .ss_n_out(ss_n_in), .sda_out(sda_p), .scl_out(scl_p));
  task automatic test_done;
    if (num_errors == 0 && tests_run > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic cmp(input string nm, input logic [31:0] ex, input logic [31:0] got);
    tests_run++;
    if (got !== ex) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", nm, ex, got);
    end
  endtask
  task automatic cmpb(input string nm, input logic ex, input logic got);
    cmp(nm, {31'h0, ex}, {31'h0, got});
  endtask
  // One bus transfer; the request holds until ready is sampled high
  task automatic apb(input logic w, input logic [7:0] idx, input logic [31:0] wd);
    int k;
    psel_in <= 1'b1;
    pwrite_in <= w;
    paddr_in <= {2'b00, idx, 2'b00};
    pwdata_in <= wd;
    @(posedge clk_sys_in);
    penable_in <= 1'b1;
    k = 0;
    do begin
      @(posedge clk_sys_in);
      k++;
    end while (pready_out !== 1'b1 && k < 20);
    if (k >= 20) begin
      num_errors++;
      test_done();
    end
    rd = prdata_out;
    err = pslverr_out;
    psel_in <= 1'b0;
    penable_in <= 1'b0;
    @(posedge clk_sys_in);
  endtask
  // Writes leave two clocks for registered pin outputs to follow
  task automatic wr(input logic [7:0] idx, input logic [31:0] d);
    apb(1'b1, idx, d);
    repeat (2) @(posedge clk_sys_in);
  endtask
  task automatic chk(input logic [7:0] idx, input logic [31:0] ex, input string nm);
    apb(1'b0, idx, 32'h0);
    cmp(nm, ex, rd);
  endtask
  // Clocks until the watched clock line changes, bounded
  task automatic edge_wait(input logic i2c, output int c);
    logic v;
    v = i2c ? scl_oe_out : sck_out;
    c = 0;
    while ((i2c ? scl_oe_out : sck_out) === v && c < 300) begin
      @(posedge clk_sys_in);
      c++;
    end
    if (c >= 300) begin
      num_errors++;
      test_done();
    end
  endtask
  initial begin
    repeat (6) @(posedge clk_sys_in);
    reset_in <= 1'b0;
    @(posedge clk_sys_in);
    chk(CTRL_IDX, 32'(CTRL_RESET), "ctrl reset");
    apb(1'b0, 8'h3f, 32'h0);
    cmpb("unmapped error", 1'b1, err);
    // Master modes: rate, busy write refused, no overflow without reads
    for (int m = 0; m < 4; m++) begin
      wr(CTRL_IDX, 32'h20 | 32'(m));
      cmpb("spi owned", 1'b1, spi_pins_own_out);
      wr(BUF_IDX, 32'h5a);
      wr(BUF_IDX, 32'h33);
      edge_wait(1'b0, n);
      edge_wait(1'b0, n);
      cmp("sck half period", halves[m], 32'(n));
      chk(CTRL_IDX, 32'ha0 | 32'(m), "master collision");
      wr(CTRL_IDX, 32'h20 | 32'(m));
      repeat (600) @(posedge clk_sys_in);
      wr(BUF_IDX, 32'hc3);
      repeat (600) @(posedge clk_sys_in);
      chk(CTRL_IDX, 32'h20 | 32'(m), "master flags");
      wr(CTRL_IDX, 32'h0);
      cmpb("spi released", 1'b0, spi_pins_own_out);
    end
    for (int c = 0; c < 2; c++) begin
      wr(CTRL_IDX, 32'h20 | 32'(c << 4));
      cmpb("sck idle", c[0], sck_out);
    end
    // Slave with select: read keeps the buffer free, unread byte overflows
    wr(CTRL_IDX, 32'h24);
    cmpb("select owned", 1'b1, ss_pin_own_out);
    cmpb("slave sck input", 1'b0, sck_oe_out);
    p_u.send(8'ha5);
    chk(BUF_IDX, 32'ha5, "slave byte");
    p_u.send(8'h3c);
    p_u.send(8'hc3);
    chk(CTRL_IDX, 32'h64, "slave overflow");
    chk(BUF_IDX, 32'h3c, "kept byte");
    fork
      p_u.send(8'h11);
      begin
        repeat (20) @(posedge clk_sys_in);
        wr(BUF_IDX, 32'h77);
      end
    join
    chk(CTRL_IDX, 32'he4, "slave collision");
    cmpb("irq masked", 1'b0, irq_out);
    wr(IRQ_EN_IDX, 32'h1);
    cmpb("irq raised", 1'b1, irq_out);
    wr(IRQ_CLR_IDX, 32'h1);
    cmpb("irq cleared", 1'b0, irq_out);
    chk(IRQ_STAT_IDX, 32'h6, "irq status");
    wr(CTRL_IDX, 32'h25);
    cmpb("select free", 1'b0, ss_pin_own_out);
    // Bus modes: ownership, stretch control, master rate
    wr(CTRL_IDX, 32'h26);
    cmpb("i2c owned", 1'b1, i2c_pins_own_out);
    cmpb("scl stretched", 1'b1, scl_oe_out);
    wr(CTRL_IDX, 32'h37);
    cmpb("scl released", 1'b0, scl_oe_out);
    wr(CTRL_IDX, 32'h0);
    cmpb("i2c released", 1'b0, i2c_pins_own_out);
    // Bus slave: matched address loads the buffer, unread it makes the data byte overflow
    wr(RELOAD_IDX, 32'ha4);
    wr(CTRL_IDX, 32'h36);
    p_u.frame({8'ha4, 1'b1, 8'h3c, 1'b1});
    chk(CTRL_IDX, 32'h76, "i2c overflow");
    chk(BUF_IDX, 32'ha4, "i2c kept byte");
    wr(RELOAD_IDX, 32'h1);
    wr(CTRL_IDX, 32'h28);
    cmpb("master ignores polarity", 1'b0, scl_oe_out);
    wr(BUF_IDX, 32'h96);
    edge_wait(1'b1, n);
    edge_wait(1'b1, n);
    cmp("scl half period", 32'h4, 32'(n));
    test_done();
  end
endmodule // ssc_top_bench

// file: bench/ssc_top_monitor.sv
// Port-level assertions and covers for the serial port control block
`timescale 1ns/1ns
module ssc_top_monitor (
  input wire logic clk_sys_in,
  input wire logic reset_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pready_out,
  input wire logic pslverr_out,
  input wire logic sck_out,
  input wire logic sck_oe_out,
  input wire logic sdo_oe_out,
  input wire logic sda_out,
  input wire logic sda_oe_out,
  input wire logic scl_out,
  input wire logic scl_oe_out,
  input wire logic spi_pins_own_out,
  input wire logic i2c_pins_own_out
);
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (reset_in);
  // Bus answer: one wait state, a single-cycle ready, errors only with ready
  a_ready_one_wait: assert property ($rose(penable_in) && psel_in |=> pready_out)
    else $error("ready not one cycle after access start");
  a_ready_pulse: assert property (pready_out |=> !pready_out)
    else $error("ready held longer than one cycle");
  a_err_with_ready: assert property (pslverr_out |-> pready_out)
    else $error("error without ready");
  // A pin is driven only while the port owns it, so a disabled port never fights
  a_sck_owned: assert property (sck_oe_out |-> spi_pins_own_out)
    else $error("clock driven without ownership");
  a_sdo_owned: assert property (sdo_oe_out |-> spi_pins_own_out)
    else $error("data out driven without ownership");
  a_i2c_owned: assert property (scl_oe_out || sda_oe_out |-> i2c_pins_own_out)
    else $error("bus line driven without ownership");
  a_owners_apart: assert property (spi_pins_own_out |-> !i2c_pins_own_out)
    else $error("both pin groups owned");
  a_open_drain: assert property (i2c_pins_own_out |-> !sda_out && !scl_out)
    else $error("bus line driven high");
  // Main scenarios reached
  c_refused: cover property (pslverr_out);
  c_scl_low: cover property (scl_oe_out && i2c_pins_own_out);
  c_sck_runs: cover property (sck_oe_out && $changed(sck_out));
endmodule // ssc_top_monitor

bind ssc_top ssc_top_monitor mon_u (.*);

// file: rtl/ssc_bitclk_div.sv
// Master bit-clock divider: one tick per half period of the serial clock
`timescale 1ns/1ns
module ssc_bitclk_div
  import ssc_pkg::*;
(
  input  wire logic       clk_sys_in,
  input  wire logic       reset_in,
  input  wire logic       ce_in,
  input  wire logic       run_in,
  input  wire logic [3:0] mode_in,
  input  wire logic [7:0] reload_in,
  input  wire logic       timer_in,
  output logic            half_tick_out
);
  logic [9:0] cnt_q;
  logic [9:0] half_len;
  logic       timer_prev_q;
  logic       timer_rise;

  // Half period per mode; the timer mode toggles once per timer pulse
  always_comb begin
    unique case (mode_in)
      MODE_SPI_M4:  half_len = HALF_DIV4;
      MODE_SPI_M16: half_len = HALF_DIV16;
      MODE_SPI_M64: half_len = HALF_DIV64;
      MODE_I2C_M:   half_len = {1'b0, reload_in, 1'b0} + 10'h002;
      default:      half_len = HALF_DIV4;
    endcase
  end

  assign timer_rise = timer_in & ~timer_prev_q;

  // Timer edge detect
  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      timer_prev_q <= 1'b0;
    end else if (ce_in) begin
      timer_prev_q <= timer_in;
    end
  end

  // Counter restarts when idle so the first half period is full in the counter modes
  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      cnt_q         <= 10'h000;
      half_tick_out <= 1'b0;
    end else if (ce_in) begin
      half_tick_out <= 1'b0;
      if (!run_in) begin
        cnt_q <= 10'h000;
      end else if (mode_in == MODE_SPI_MTMR) begin
        half_tick_out <= timer_rise;
      end else if (cnt_q + 10'h001 >= half_len) begin
        cnt_q         <= 10'h000;
        half_tick_out <= 1'b1;
      end else begin
        cnt_q <= cnt_q + 10'h001;
      end
    end
  end
endmodule // ssc_bitclk_div

// file: rtl/ssc_top.sv
// Synchronous serial port control: modes, bit clock, pin ownership and error flags
//
// How it works
// - Master mode: buffer write when a transfer cannot start sets write collision.
// - Slave mode: buffer write while a word is shifting sets collision; stays set.
// - SPI slave: byte arriving with unread buffer sets overflow, new byte discarded.
// - SPI overflow happens only in slave mode, never in master mode.
// - I2C: byte arriving with unread buffer sets overflow; sticky until cleared.
// - Port enable in SPI mode takes clock and data pins, and the select pin in mode 4 only; else released.
// - Port enable in I2C mode takes SDA and SCL; else released.
// - SPI clock idles high when polarity is 1, low when 0.
// - I2C slave holds SCL low while polarity is 0; ignored in I2C master.
// - Modes 0..2 are SPI master at clock divided by 4, 16, 64.
// - Mode 3 is SPI master clocked by the second timer output halved.
// - Mode 4 is SPI slave on the clock pin gated by slave select.
// - Mode 5 is SPI slave ignoring slave select, leaving that pin free.
// - Modes 6 and 7 are I2C slave with 7-bit and 10-bit addressing.
// - Mode 8 is I2C master, SCL at clock over four times reload plus one.
`timescale 1ns/1ns
module ssc_top
  import ssc_pkg::*;
(
  input  wire logic        clk_sys_in,
  input  wire logic        reset_in,
  input  wire logic        ce_in,
  // APB slave
  input  wire logic        psel_in,
  input  wire logic        penable_in,
  input  wire logic        pwrite_in,
  input  wire logic [11:0] paddr_in,
  input  wire logic [31:0] pwdata_in,
  output logic             pready_out,
  output logic [31:0]      prdata_out,
  output logic             pslverr_out,
  output logic             irq_out,
  // Pins and timer
  input  wire logic        timer_in,
  input  wire logic        sck_in,
  output logic             sck_out,
  output logic             sck_oe_out,
  output logic             sdo_out,
  output logic             sdo_oe_out,
  input  wire logic        sdi_in,
  input  wire logic        ss_n_in,
  input  wire logic        sda_in,
  output logic             sda_out,
  output logic             sda_oe_out,
  input  wire logic        scl_in,
  output logic             scl_out,
  output logic             scl_oe_out,
  output logic             spi_pins_own_out,
  output logic             ss_pin_own_out,
  output logic             i2c_pins_own_out
);
  typedef enum logic [1:0] {ST_IDLE, ST_MASTER, ST_SLAVE} ssc_state_e;

  // Register address match
  function automatic logic hit(input logic [11:0] addr, input logic [7:0] idx);
    hit = (addr[11:2] == {2'b00, idx}) && (addr[1:0] == 2'b00);
  endfunction

  ssc_state_e       st_q;
  logic [7:0]       ctrl_q, reload_q, rx_q, shift_q, cap_q, next_byte;
  logic [4:0]       edge_q;
  logic [3:0]       bit_q, mode;
  logic [IRQ_W-1:0] irq_stat_q, irq_en_q;
  logic [4:0]       pin_meta_q, pin_sync_q, pin_prev_q;
  logic [31:0]      rd_data;
  // Engine state bits
  logic             full_q, done_q, clk_act_q, sdo_q;
  logic             i2c_active_q, addr_phase_q, matched_q, bus_busy_q;
  // Bus decode, flag events, mode decode and pin events
  logic             half_tick, mapped, commit, wr_buf, rd_buf, wr_ctrl, write_collision_flag_ev, ovf_ev;
  logic             en, cpol, spi_m, spi_s, i2c_s, i2c_m, master, ss_ok;
  logic             sck_lead, sck_trail, scl_rise, i2c_start, i2c_stop, addr_hit, din;

  assign mode   = ctrl_q[3:0];
  assign en     = ctrl_q[CTRL_EN_BIT];
  assign cpol   = ctrl_q[CTRL_CPOL_BIT];
  assign spi_m  = en && (mode <= MODE_SPI_MTMR);
  assign spi_s  = en && ((mode == MODE_SPI_SSS) || (mode == MODE_SPI_SNSS));
  assign i2c_s  = en && ((mode == MODE_I2C_S7) || (mode == MODE_I2C_S10));
  assign i2c_m  = en && (mode == MODE_I2C_M);
  assign master = spi_m || i2c_m;

  // Pins cross into this clock through two flops; order {scl, sda, ss_n, sdi, sck}
  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      pin_meta_q <= 5'h1f;
      pin_sync_q <= 5'h1f;
      pin_prev_q <= 5'h1f;
    end else if (ce_in) begin
      pin_meta_q <= {scl_in, sda_in, ss_n_in, sdi_in, sck_in};
      pin_sync_q <= pin_meta_q;
      pin_prev_q <= pin_sync_q;
    end
  end

  // Edges seen on the synchronised pins
  assign ss_ok     = (mode == MODE_SPI_SNSS) || !pin_sync_q[2];
  assign sck_lead  = (pin_prev_q[0] == cpol) && (pin_sync_q[0] != cpol);
  assign sck_trail = (pin_prev_q[0] != cpol) && (pin_sync_q[0] == cpol);
  assign scl_rise  = !pin_prev_q[4] && pin_sync_q[4];
  assign i2c_start = pin_prev_q[4] && pin_sync_q[4] && pin_prev_q[3] && !pin_sync_q[3];
  assign i2c_stop  = pin_prev_q[4] && pin_sync_q[4] && !pin_prev_q[3] && pin_sync_q[3];
  assign din       = i2c_m ? pin_sync_q[3] : pin_sync_q[1];
  assign next_byte = {shift_q[6:0], i2c_s ? pin_sync_q[3] : pin_sync_q[1]};

  // 7-bit address in reload[7:1]; 10-bit matches the header byte with reload[2:1]
  assign addr_hit = (mode == MODE_I2C_S7) ? (next_byte[7:1] == reload_q[7:1]) :
                    (next_byte[7:1] == {TEN_BIT_HDR, reload_q[2:1]});

  ssc_bitclk_div u_div (
    .clk_sys_in    (clk_sys_in),
    .reset_in      (reset_in),
    .ce_in         (ce_in),
    .run_in        (st_q == ST_MASTER),
    .mode_in       (mode),
    .reload_in     (reload_q),
    .timer_in      (timer_in),
    .half_tick_out (half_tick)
  );

  // APB decode; one wait state so read data can come from a flop
  assign commit  = psel_in && penable_in && pready_out;
  assign mapped  = hit(paddr_in, CTRL_IDX) || hit(paddr_in, BUF_IDX) ||
                   hit(paddr_in, RELOAD_IDX) || hit(paddr_in, IRQ_STAT_IDX) ||
                   hit(paddr_in, IRQ_EN_IDX) || hit(paddr_in, IRQ_CLR_IDX) ||
                   hit(paddr_in, PIN_STAT_IDX);
  assign wr_buf  = commit && pwrite_in && hit(paddr_in, BUF_IDX);
  assign rd_buf  = commit && !pwrite_in && hit(paddr_in, BUF_IDX);
  assign wr_ctrl = commit && pwrite_in && hit(paddr_in, CTRL_IDX);

  // Master refuses while busy, or while another master holds the I2C bus
  assign write_collision_flag_ev = wr_buf && ((master && ((st_q == ST_MASTER) ||
                   (i2c_m && bus_busy_q))) ||
                   ((spi_s || i2c_s) && (bit_q != 4'h0)));

  // Overflow only for slave SPI and any I2C reception
  assign ovf_ev = done_q && full_q && (spi_s || i2c_s || i2c_m);

  always_comb begin
    rd_data = 32'h0000_0000;
    if (hit(paddr_in, CTRL_IDX)) begin
      rd_data[7:0] = ctrl_q;
    end else if (hit(paddr_in, BUF_IDX)) begin
      rd_data[7:0] = rx_q;
    end else if (hit(paddr_in, RELOAD_IDX)) begin
      rd_data[7:0] = reload_q;
    end else if (hit(paddr_in, IRQ_STAT_IDX)) begin
      rd_data[IRQ_W-1:0] = irq_stat_q;
    end else if (hit(paddr_in, IRQ_EN_IDX)) begin
      rd_data[IRQ_W-1:0] = irq_en_q;
    end else if (hit(paddr_in, PIN_STAT_IDX)) begin
      rd_data[2:0] = {bus_busy_q, st_q == ST_MASTER, full_q};
    end
  end

  // APB answer
  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      pready_out  <= 1'b0;
      prdata_out  <= 32'h0000_0000;
      pslverr_out <= 1'b0;
    end else if (ce_in) begin
      pready_out  <= psel_in && penable_in && !pready_out;
      prdata_out  <= (!pwrite_in && mapped) ? rd_data : 32'h0000_0000;
      pslverr_out <= psel_in && penable_in && !pready_out && !mapped;
    end
  end

  // Control register; hardware sets of the flags beat a software clear
  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      ctrl_q   <= CTRL_RESET;
      reload_q <= RELOAD_RESET;
    end else if (ce_in) begin
      if (wr_ctrl) begin
        ctrl_q[5:0] <= pwdata_in[5:0];
        // Writing one leaves a flag as it is; only zero clears
        if (!pwdata_in[CTRL_WRITE_COLLISION_FLAG_BIT]) ctrl_q[CTRL_WRITE_COLLISION_FLAG_BIT] <= 1'b0;
        if (!pwdata_in[CTRL_OVF_BIT])  ctrl_q[CTRL_OVF_BIT]  <= 1'b0;
      end
      if (write_collision_flag_ev) ctrl_q[CTRL_WRITE_COLLISION_FLAG_BIT] <= 1'b1;
      if (ovf_ev)  ctrl_q[CTRL_OVF_BIT]  <= 1'b1;
      if (commit && pwrite_in && hit(paddr_in, RELOAD_IDX)) begin
        reload_q <= pwdata_in[7:0];
      end
    end
  end

  // Receive buffer; an overflowing byte is dropped and the old one kept
  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      rx_q   <= 8'h00;
      full_q <= 1'b0;
    end else if (ce_in) begin
      if (rd_buf) full_q <= 1'b0;
      if (done_q && !ovf_ev) begin
        rx_q   <= cap_q;
        full_q <= 1'b1;
      end
      if (!en) full_q <= 1'b0;
    end
  end

  // I2C bus activity seen on the pins, for busy checks and the pin status register
  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      bus_busy_q <= 1'b0;
    end else if (ce_in) begin
      if (i2c_start && (st_q != ST_MASTER)) bus_busy_q <= 1'b1;
      else if (i2c_stop || !en) bus_busy_q <= 1'b0;
    end
  end

  // Shift engine: master byte transfers and slave reception
  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      st_q         <= ST_IDLE;
      shift_q      <= 8'h00;
      cap_q        <= 8'h00;
      edge_q       <= 5'h00;
      bit_q        <= 4'h0;
      done_q       <= 1'b0;
      clk_act_q    <= 1'b0;
      sdo_q        <= 1'b1;
      i2c_active_q <= 1'b0;
      addr_phase_q <= 1'b0;
      matched_q    <= 1'b0;
    end else if (ce_in) begin
      done_q <= 1'b0;
      if (!en) begin
        st_q         <= ST_IDLE;
        edge_q       <= 5'h00;
        bit_q        <= 4'h0;
        clk_act_q    <= 1'b0;
        i2c_active_q <= 1'b0;
        matched_q    <= 1'b0;
      end else begin
        unique case (st_q)
          ST_IDLE: begin
            if (master && wr_buf && !write_collision_flag_ev) begin
              shift_q   <= pwdata_in[7:0];
              sdo_q     <= pwdata_in[7];
              edge_q    <= 5'h00;
              clk_act_q <= 1'b0;
              st_q      <= ST_MASTER;
            end else if (spi_s || i2c_s) begin
              st_q <= ST_SLAVE;
            end
          end
          ST_MASTER: begin
            if (half_tick) begin
              edge_q    <= edge_q + 5'h01;
              clk_act_q <= !clk_act_q;
              if (!edge_q[0]) begin
                shift_q <= {shift_q[6:0], din};
              end else begin
                // Ninth I2C clock releases SDA for the acknowledge
                sdo_q <= (edge_q == SPI_LAST_EDGE) ? 1'b1 : shift_q[7];
              end
              if (edge_q == (i2c_m ? I2C_LAST_EDGE : SPI_LAST_EDGE)) begin
                st_q      <= ST_IDLE;
                clk_act_q <= 1'b0;
                sdo_q     <= 1'b1;
                done_q    <= 1'b1;
                cap_q     <= i2c_m ? shift_q : {shift_q[6:0], din};
              end
            end
          end
          ST_SLAVE: begin
            if (!(spi_s || i2c_s)) begin
              st_q  <= ST_IDLE;
              bit_q <= 4'h0;
            end else if (wr_buf && !write_collision_flag_ev) begin
              shift_q <= pwdata_in[7:0];
              sdo_q   <= pwdata_in[7];
            end else if (spi_s && !ss_ok) begin
              bit_q <= 4'h0;
            end else if (spi_s && sck_lead) begin
              shift_q <= next_byte;
              bit_q   <= (bit_q == LAST_BIT) ? 4'h0 : bit_q + 4'h1;
              if (bit_q == LAST_BIT) begin
                done_q <= 1'b1;
                cap_q  <= next_byte;
              end
            end else if (spi_s && sck_trail) begin
              sdo_q <= shift_q[7];
            end else if (i2c_s && i2c_start) begin
              i2c_active_q <= 1'b1;
              addr_phase_q <= 1'b1;
              matched_q    <= 1'b0;
              bit_q        <= 4'h0;
            end else if (i2c_s && i2c_stop) begin
              i2c_active_q <= 1'b0;
              bit_q        <= 4'h0;
            end else if (i2c_s && i2c_active_q && scl_rise) begin
              bit_q <= (bit_q == I2C_ACK_BIT) ? 4'h0 : bit_q + 4'h1;
              if (bit_q != I2C_ACK_BIT) shift_q <= next_byte;
              if (bit_q == LAST_BIT) begin
                addr_phase_q <= 1'b0;
                cap_q        <= next_byte;
                if (addr_phase_q) matched_q <= addr_hit;
                done_q <= addr_phase_q ? addr_hit : matched_q;
              end
            end
          end
        endcase
      end
    end
  end

  // Pin ownership and drivers; released pins go back to general I/O
  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      spi_pins_own_out <= 1'b0;
      ss_pin_own_out   <= 1'b0;
      i2c_pins_own_out <= 1'b0;
      sck_out          <= 1'b0;
      sck_oe_out       <= 1'b0;
      sdo_out          <= 1'b1;
      sdo_oe_out       <= 1'b0;
      sda_out          <= 1'b0;
      sda_oe_out       <= 1'b0;
      scl_out          <= 1'b0;
      scl_oe_out       <= 1'b0;
    end else if (ce_in) begin
      spi_pins_own_out <= spi_m || spi_s;
      ss_pin_own_out   <= en && (mode == MODE_SPI_SSS);
      i2c_pins_own_out <= i2c_s || i2c_m;
      sck_out          <= cpol ^ clk_act_q;
      sck_oe_out       <= spi_m;
      sdo_out          <= sdo_q;
      sdo_oe_out       <= spi_m || (spi_s && ss_ok);
      sda_out          <= 1'b0;
      sda_oe_out       <= i2c_m && (st_q == ST_MASTER) && !sdo_q;
      scl_out          <= 1'b0;
      // Stretch only as slave; polarity has no say in master mode
      scl_oe_out       <= (i2c_s && !cpol) ||
                          (i2c_m && (st_q == ST_MASTER) && !clk_act_q);
    end
  end

  // Sticky interrupt status, write-one-to-clear; a new event wins over a clear
  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      irq_stat_q <= IRQ_RESET;
      irq_en_q   <= IRQ_RESET;
      irq_out    <= 1'b0;
    end else if (ce_in) begin
      if (commit && pwrite_in && hit(paddr_in, IRQ_EN_IDX)) begin
        irq_en_q <= pwdata_in[IRQ_W-1:0];
      end
      irq_stat_q <= (irq_stat_q &
                     ~((commit && pwrite_in && hit(paddr_in, IRQ_CLR_IDX)) ?
                       pwdata_in[IRQ_W-1:0] : IRQ_RESET)) |
                    {done_q && !ovf_ev, ovf_ev, write_collision_flag_ev};
      irq_out    <= |(irq_stat_q & irq_en_q);
    end
  end
endmodule // ssc_top

// file: shared/ssc_pkg.sv
// Constants shared by the serial port control block and its bit-clock divider
package ssc_pkg;
  // Register indices; byte address is four times the index
  localparam logic [7:0] CTRL_IDX     = 8'h11;
  localparam logic [7:0] BUF_IDX      = 8'h13;
  localparam logic [7:0] RELOAD_IDX   = 8'h14;
  localparam logic [7:0] IRQ_STAT_IDX = 8'h15;
  localparam logic [7:0] IRQ_EN_IDX   = 8'h16;
  localparam logic [7:0] IRQ_CLR_IDX  = 8'h17;
  localparam logic [7:0] PIN_STAT_IDX = 8'h18;

  // Control register fields
  localparam int         CTRL_WRITE_COLLISION_FLAG_BIT = 7;
  localparam int         CTRL_OVF_BIT  = 6;
  localparam int         CTRL_EN_BIT   = 5;
  localparam int         CTRL_CPOL_BIT = 4;
  localparam logic [7:0] CTRL_RESET    = 8'h00;
  localparam logic [7:0] RELOAD_RESET  = 8'h00;

  // Mode select codes
  localparam logic [3:0] MODE_SPI_M4   = 4'h0;
  localparam logic [3:0] MODE_SPI_M16  = 4'h1;
  localparam logic [3:0] MODE_SPI_M64  = 4'h2;
  localparam logic [3:0] MODE_SPI_MTMR = 4'h3;
  localparam logic [3:0] MODE_SPI_SSS  = 4'h4;
  localparam logic [3:0] MODE_SPI_SNSS = 4'h5;
  localparam logic [3:0] MODE_I2C_S7   = 4'h6;
  localparam logic [3:0] MODE_I2C_S10  = 4'h7;
  localparam logic [3:0] MODE_I2C_M    = 4'h8;

  // Half periods of the master bit clock, in system clocks
  localparam logic [9:0] HALF_DIV4  = 10'h002;
  localparam logic [9:0] HALF_DIV16 = 10'h008;
  localparam logic [9:0] HALF_DIV64 = 10'h020;

  // Edge counts of a master byte: 8 clocks for SPI, 9 for I2C with acknowledge
  localparam logic [4:0] SPI_LAST_EDGE = 5'h0f;
  localparam logic [4:0] I2C_LAST_EDGE = 5'h11;
  localparam logic [3:0] I2C_ACK_BIT   = 4'h8;
  localparam logic [3:0] LAST_BIT      = 4'h7;

  // Upper address byte pattern of 10-bit addressing
  localparam logic [4:0] TEN_BIT_HDR = 5'h1e;

  // Interrupt status, enable and clear layout
  localparam int         IRQ_WRITE_COLLISION_FLAG_BIT = 0;
  localparam int         IRQ_OVF_BIT  = 1;
  localparam int         IRQ_DONE_BIT = 2;
  localparam int         IRQ_W        = 3;
  localparam logic [2:0] IRQ_RESET    = 3'h0;
endpackage : ssc_pkg
